// ===== hdl/fpc_pkg.sv
// constants and state types of the front-panel controller
package fpc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ        = 125_000_000;
  localparam int CYC_PER_MS    = CLK_HZ / 1000;
  localparam int EXIT_HOLD_MS  = 2000;
  localparam int MODE_HOLD_MS  = 3000;
  localparam int DEBOUNCE_MS   = 10;
  localparam int BLINK_MS      = 250;
  localparam int EXIT_HOLD_CYC = CYC_PER_MS * EXIT_HOLD_MS;
  localparam int MODE_HOLD_CYC = CYC_PER_MS * MODE_HOLD_MS;
  localparam int DEBOUNCE_CYC  = CYC_PER_MS * DEBOUNCE_MS;
  localparam int BLINK_CYC     = CYC_PER_MS * BLINK_MS;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ISTAT  = 8'h08;
  localparam logic [7:0] ADDR_IMASK  = 8'h0C;
  localparam logic [7:0] ADDR_DCI    = 8'h10;
  localparam int CTRL_RST_ASSIGN = 0;
  localparam int CTRL_RST_LEVEL  = 1;
  localparam int CTRL_REM_RUN    = 2;
  localparam int CTRL_REM_DIAL   = 3;
  localparam int CTRL_EDITING    = 4;
  localparam int CTRL_DISP_VALUE = 5;
  localparam int CTRL_DISP_UNIT  = 6;
  localparam int DCI_TIME_LSB    = 16;
  localparam int STAT_REMOTE     = 0;
  localparam int STAT_PROG       = 1;
  localparam int STAT_FAULT      = 4;
  localparam int STAT_RELAY      = 5;
  localparam int STAT_FAN        = 6;
  localparam int STAT_READY      = 7;
  localparam logic [6:0] CTRL_RST = 7'h00;
  // dc injection defaults: current in thousandths of nominal, time in ms
  localparam logic [9:0] DCI_CUR_RST  = 10'h2BC;
  localparam logic [9:0] DCI_TIME_RST = 10'h1F4;
  // ----------------------------------------
  // interrupt events
  // ----------------------------------------
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_CLEAR = 1;
  localparam int IRQ_MODE  = 2;
  localparam int IRQ_CFG   = 3;
  localparam int NIRQ      = 4;
  // ----------------------------------------
  // keys
  // ----------------------------------------
  localparam int K_EXIT = 0;
  localparam int K_MODE = 1;
  localparam int K_STOP = 2;
  localparam int K_RUN  = 3;
  localparam int K_CONF = 4;
  localparam int K_PUSH = 5;
  localparam int NKEY   = 6;
  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] db_cnt;
    logic        stable;
    logic [31:0] hold_cnt;
    logic        long_done;
    logic        press;
    logic        short_ev;
    logic        long_ev;
  } fpc_key_st_t;
  typedef struct packed {
    logic a_q;
    logic cw;
    logic ccw;
  } fpc_jog_st_t;
  typedef struct packed {
    logic ref_led;
    logic mon_led;
    logic cfg_led;
    logic value_led;
    logic unit_led;
  } fpc_led_t;
  typedef struct packed {
    logic stop;
    logic run;
    logic inc;
    logic dec;
    logic nxt;
    logic prv;
    logic sel;
    logic exit_ev;
    logic discard;
  } fpc_cmd_t;
endpackage : fpc_pkg

// ===== hdl/fpc_key.sv
// debounced key with press, short-release and long-hold events
`timescale 1ns/100ps
module fpc_key #(
  parameter int DB_CYC   = 16,
  parameter int HOLD_CYC = 16
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic raw,
  output logic      press_ev,
  output logic      short_ev,
  output logic      long_ev
);
  fpc_pkg::fpc_key_st_t s;
  fpc_pkg::fpc_key_st_t next_s;

  always_comb
  begin
    next_s          = s;
    next_s.press    = 1'b0;
    next_s.short_ev = 1'b0;
    next_s.long_ev  = 1'b0;
    if (raw != s.stable)
    begin
      if (s.db_cnt >= 32'(DB_CYC - 1))
      begin
        next_s.stable    = raw;
        next_s.db_cnt    = 32'h0;
        next_s.hold_cnt  = 32'h0;
        next_s.long_done = 1'b0;
        next_s.press     = raw;
        next_s.short_ev  = !raw && !s.long_done;
      end
      else
        next_s.db_cnt = s.db_cnt + 32'h1;
    end
    else
    begin
      next_s.db_cnt = 32'h0;
      // hold timer runs only on a stable press, long event once per hold
      if (s.stable && !s.long_done)
      begin
        if (s.hold_cnt >= 32'(HOLD_CYC - 1))
        begin
          next_s.long_done = 1'b1;
          next_s.long_ev   = 1'b1;
        end
        else
          next_s.hold_cnt = s.hold_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      s <= '0;
    else
      s <= next_s;
  end

  assign press_ev = s.press;
  assign short_ev = s.short_ev;
  assign long_ev  = s.long_ev;
endmodule : fpc_key

// ===== hdl/fpc_jog.sv
// quadrature jog dial step decoder
`timescale 1ns/100ps
module fpc_jog (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic a,
  input  wire logic b,
  output logic      cw,
  output logic      ccw
);
  fpc_pkg::fpc_jog_st_t s;
  fpc_pkg::fpc_jog_st_t next_s;

  // one step per rising edge of phase a; b gives the direction
  always_comb
  begin
    next_s     = s;
    next_s.a_q = a;
    next_s.cw  = a && !s.a_q && !b;
    next_s.ccw = a && !s.a_q && b;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      s <= '0;
    else
      s <= next_s;
  end

  assign cw  = s.cw;
  assign ccw = s.ccw;
endmodule : fpc_jog

// ===== hdl/fpc_top.sv
// drive front-panel and supervisory controller
// Operation
// - relay energized while powered with no fault, dropped at once on fault
// - fault cleared by the assigned reset input at its active level
// - fan on only while thermal state asks for ventilation
// - motor thermal memory cleared at power-up unless retention is set
// - exit key leaves menu, or discards an edited value
// - in local, exit held 2 s toggles control and programming mode
// - mode held 3 s toggles remote/local; short press toggles mode
// - stop key issues a motor stop command
// - run key runs in local, in remote only when enabled
// - dial rotation steps the reference in local, in remote if enabled
// - dial steps navigate menus, dial push selects
// - local: mode LEDs blink together in programming, chase in control
// - while editing, configuration and value LEDs are steady on
// - value LED follows numeric display, unit LED follows unit display
// - dc injection defaults to 0.7 nominal current for 0.5 s
// - ready indication after power-up when motor frequency is set
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
module fpc_top #(
  parameter int EXIT_HOLD_CYC = fpc_pkg::EXIT_HOLD_CYC,
  parameter int MODE_HOLD_CYC = fpc_pkg::MODE_HOLD_CYC,
  parameter int DEBOUNCE_CYC  = fpc_pkg::DEBOUNCE_CYC,
  parameter int BLINK_CYC     = fpc_pkg::BLINK_CYC
) (
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             IRQ,
  input  wire logic        FAULT_DET,
  input  wire logic        FAULT_RESET_IN,
  input  wire logic        THERM_VENT_REQ,
  input  wire logic        THERM_RETAIN,
  input  wire logic        STD_FREQ_SET,
  input  wire logic        EXIT_KEY,
  input  wire logic        MODE_KEY,
  input  wire logic        STOP_KEY,
  input  wire logic        RUN_KEY,
  input  wire logic        CONFIRM_KEY,
  input  wire logic        DIAL_A,
  input  wire logic        DIAL_B,
  input  wire logic        DIAL_PUSH,
  output logic             FAULT_STATUS_RELAY,
  output logic             FAN_EN,
  output logic             THERM_MEM_CLR,
  output logic             READY_IND,
  output logic             STOP_CMD,
  output logic             RUN_CMD,
  output logic             REF_INC,
  output logic             REF_DEC,
  output logic             NAV_NEXT,
  output logic             NAV_PREV,
  output logic             SELECT,
  output logic             EXIT_EVT,
  output logic             DISCARD_EVT,
  output logic             REMOTE_CFG,
  output logic             PROG_MODE,
  output logic             LED_REF,
  output logic             LED_MON,
  output logic             LED_CFG,
  output logic             LED_VALUE,
  output logic             LED_UNIT,
  output logic      [9:0]  DCI_CURRENT,
  output logic      [9:0]  DCI_TIME
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    PH_REF = 3'h1,
    PH_MON = 3'h2,
    PH_CFG = 3'h4
  } fpc_phase_t;

  typedef struct packed {
    logic                 started;
    logic                 ready;
    logic                 therm_clr;
    logic                 fault;
    logic                 relay;
    logic                 fan;
    logic                 remote;
    logic                 prog;
    logic [6:0]           ctrl;
    logic [fpc_pkg::NIRQ-1:0] istat;
    logic [fpc_pkg::NIRQ-1:0] imask;
    logic [9:0]           dci_cur;
    logic [9:0]           dci_time;
    logic [31:0]          rdata;
    logic [31:0]          tick;
    logic                 blink;
    fpc_phase_t           phase;
    fpc_pkg::fpc_led_t    led;
    fpc_pkg::fpc_cmd_t    cmd;
  } fpc_top_st_t;

  fpc_top_st_t s;
  fpc_top_st_t next_s;

  // ----------------------------------------
  // keys and dial
  // ----------------------------------------
  logic [fpc_pkg::NKEY-1:0] key_raw;
  logic [fpc_pkg::NKEY-1:0] key_press;
  logic [fpc_pkg::NKEY-1:0] key_short;
  logic [fpc_pkg::NKEY-1:0] key_long;
  logic                     dial_cw;
  logic                     dial_ccw;

  // bit order of key_raw follows the key index constants
  assign key_raw = {DIAL_PUSH, CONFIRM_KEY, RUN_KEY, STOP_KEY, MODE_KEY, EXIT_KEY};

  genvar gi;
  generate
    for (gi = 0; gi < fpc_pkg::NKEY; gi++)
    begin : g_key
      fpc_key #(
        .DB_CYC   (DEBOUNCE_CYC),
        .HOLD_CYC (gi == fpc_pkg::K_EXIT ? EXIT_HOLD_CYC : MODE_HOLD_CYC)
      ) u_key (
        .clk      (SYS_CLK),
        .srst     (SRST),
        .raw      (key_raw[gi]),
        .press_ev (key_press[gi]),
        .short_ev (key_short[gi]),
        .long_ev  (key_long[gi])
      );
    end
  endgenerate

  fpc_jog u_jog (
    .clk  (SYS_CLK),
    .srst (SRST),
    .a    (DIAL_A),
    .b    (DIAL_B),
    .cw   (dial_cw),
    .ccw  (dial_ccw)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic                     rst_active;
  logic                     editing;
  logic                     local_cfg;
  logic [fpc_pkg::NIRQ-1:0] ev;
  logic [31:0]              status_word;

  always_comb
  begin
    next_s     = s;
    ev         = '0;
    editing    = s.ctrl[fpc_pkg::CTRL_EDITING];
    local_cfg  = !s.remote;
    rst_active = s.ctrl[fpc_pkg::CTRL_RST_ASSIGN]
                 && (FAULT_RESET_IN == s.ctrl[fpc_pkg::CTRL_RST_LEVEL]);
    status_word = 32'h0;

    // straps are caught on the first clock after reset release
    next_s.started   = 1'b1;
    next_s.therm_clr = !s.started && !THERM_RETAIN;
    if (!s.started)
      next_s.ready = STD_FREQ_SET;

    // detection wins over a reset request in the same cycle
    if (FAULT_DET)
      next_s.fault = 1'b1;
    else if (rst_active)
      next_s.fault = 1'b0;
    ev[fpc_pkg::IRQ_FAULT] = FAULT_DET && !s.fault;
    ev[fpc_pkg::IRQ_CLEAR] = s.fault && !FAULT_DET && rst_active;
    // relay follows the next fault value, so it drops with the fault register one cycle after detection
    next_s.relay = !next_s.fault;
    // no hysteresis here: the thermal side decides when ventilation stops
    next_s.fan   = THERM_VENT_REQ;

    // mode and configuration
    if (key_long[fpc_pkg::K_MODE])
    begin
      next_s.remote        = !s.remote;
      ev[fpc_pkg::IRQ_CFG] = 1'b1;
    end
    // a long exit in remote is ignored; only the mode key leaves remote
    if (key_short[fpc_pkg::K_MODE]
        || (key_long[fpc_pkg::K_EXIT] && local_cfg))
    begin
      next_s.prog           = !s.prog;
      ev[fpc_pkg::IRQ_MODE] = 1'b1;
    end

    // operator commands, one-cycle pulses
    next_s.cmd.stop    = key_press[fpc_pkg::K_STOP];
    // a run press in remote without the enable is dropped, not queued
    next_s.cmd.run     = key_press[fpc_pkg::K_RUN]
                         && (local_cfg || s.ctrl[fpc_pkg::CTRL_REM_RUN]);
    // in programming mode the dial navigates, in control mode it moves the reference
    next_s.cmd.inc     = dial_cw && !s.prog
                         && (local_cfg || s.ctrl[fpc_pkg::CTRL_REM_DIAL]);
    next_s.cmd.dec     = dial_ccw && !s.prog
                         && (local_cfg || s.ctrl[fpc_pkg::CTRL_REM_DIAL]);
    next_s.cmd.nxt     = dial_cw && s.prog;
    next_s.cmd.prv     = dial_ccw && s.prog;
    next_s.cmd.sel     = key_press[fpc_pkg::K_PUSH]
                         || key_press[fpc_pkg::K_CONF];
    next_s.cmd.exit_ev = key_short[fpc_pkg::K_EXIT] && !editing;
    next_s.cmd.discard = key_short[fpc_pkg::K_EXIT] && editing;

    // indicator timing
    // one shared tick keeps blink and chaser in step; the phase moves only on a wrap
    if (s.tick >= 32'(BLINK_CYC - 1))
    begin
      next_s.tick  = 32'h0;
      next_s.blink = !s.blink;
      case (s.phase)
        PH_REF:  next_s.phase = PH_MON;
        PH_MON:  next_s.phase = PH_CFG;
        PH_CFG:  next_s.phase = PH_REF;
        default: next_s.phase = PH_REF;
      endcase
    end
    else
      next_s.tick = s.tick + 32'h1;

    // mode LEDs dark in remote, except the steady edit indication
    next_s.led = '0;
    if (local_cfg)
    begin
      if (s.prog)
      begin
        next_s.led.ref_led = s.blink;
        next_s.led.mon_led = s.blink;
        next_s.led.cfg_led = s.blink;
      end
      else
      begin
        next_s.led.ref_led = s.phase[0];
        next_s.led.mon_led = s.phase[1];
        next_s.led.cfg_led = s.phase[2];
      end
    end
    next_s.led.value_led = s.ctrl[fpc_pkg::CTRL_DISP_VALUE];
    next_s.led.unit_led  = s.ctrl[fpc_pkg::CTRL_DISP_UNIT];
    if (editing)
    begin
      next_s.led.cfg_led   = 1'b1;
      next_s.led.value_led = 1'b1;
    end

    // register writes
    // status is read-only: writes to it and to unmapped offsets are dropped
    next_s.istat = s.istat;
    if (WR)
    begin
      case (ADDR)
        fpc_pkg::ADDR_CTRL:  next_s.ctrl = WDATA[6:0];
        fpc_pkg::ADDR_ISTAT: next_s.istat = s.istat & ~WDATA[fpc_pkg::NIRQ-1:0];
        fpc_pkg::ADDR_IMASK: next_s.imask = WDATA[fpc_pkg::NIRQ-1:0];
        fpc_pkg::ADDR_DCI:
        begin
          next_s.dci_cur  = WDATA[9:0];
          next_s.dci_time = WDATA[fpc_pkg::DCI_TIME_LSB +: 10];
        end
        default: next_s.ctrl = s.ctrl;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_s.istat = next_s.istat | ev;

    // status bits gathered here so the read decode stays one line per register
    status_word[fpc_pkg::STAT_REMOTE] = s.remote;
    status_word[fpc_pkg::STAT_PROG]   = s.prog;
    status_word[fpc_pkg::STAT_FAULT]  = s.fault;
    status_word[fpc_pkg::STAT_RELAY]  = s.relay;
    status_word[fpc_pkg::STAT_FAN]    = s.fan;
    status_word[fpc_pkg::STAT_READY]  = s.ready;

    // register reads, data in the following cycle
    next_s.rdata = 32'h0;
    if (RD)
    begin
      case (ADDR)
        fpc_pkg::ADDR_CTRL:   next_s.rdata = {25'h0, s.ctrl};
        fpc_pkg::ADDR_STATUS: next_s.rdata = status_word;
        fpc_pkg::ADDR_ISTAT:  next_s.rdata = {28'h0, s.istat};
        fpc_pkg::ADDR_IMASK:  next_s.rdata = {28'h0, s.imask};
        fpc_pkg::ADDR_DCI:    next_s.rdata = {6'h0, s.dci_time, 6'h0, s.dci_cur};
        default:              next_s.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      s          <= '0;
      s.relay    <= 1'b1;
      s.ctrl     <= fpc_pkg::CTRL_RST;
      // dc injection comes back at its defaults, not at zero
      s.dci_cur  <= fpc_pkg::DCI_CUR_RST;
      s.dci_time <= fpc_pkg::DCI_TIME_RST;
      s.phase    <= PH_REF;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign RDATA              = s.rdata;
  // level from registers, so a clear or a mask write drops it on the next edge
  assign IRQ                = |(s.istat & s.imask);
  assign FAULT_STATUS_RELAY = s.relay;
  assign FAN_EN             = s.fan;
  assign THERM_MEM_CLR      = s.therm_clr;
  assign READY_IND          = s.ready;
  assign STOP_CMD           = s.cmd.stop;
  assign RUN_CMD            = s.cmd.run;
  assign REF_INC            = s.cmd.inc;
  assign REF_DEC            = s.cmd.dec;
  assign NAV_NEXT           = s.cmd.nxt;
  assign NAV_PREV           = s.cmd.prv;
  assign SELECT             = s.cmd.sel;
  assign EXIT_EVT           = s.cmd.exit_ev;
  assign DISCARD_EVT        = s.cmd.discard;
  assign REMOTE_CFG         = s.remote;
  assign PROG_MODE          = s.prog;
  assign LED_REF            = s.led.ref_led;
  assign LED_MON            = s.led.mon_led;
  assign LED_CFG            = s.led.cfg_led;
  assign LED_VALUE          = s.led.value_led;
  assign LED_UNIT           = s.led.unit_led;
  assign DCI_CURRENT        = s.dci_cur;
  assign DCI_TIME           = s.dci_time;
endmodule : fpc_top

// ===== dv/fpc_top_checker.sv
// port assertions for the front-panel controller
`timescale 1ns/100ps
module fpc_top_checker (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic FAULT_DET,
  input wire logic THERM_VENT_REQ,
  input wire logic THERM_RETAIN,
  input wire logic DIAL_A,
  input wire logic DIAL_B,
  input wire logic FAULT_STATUS_RELAY,
  input wire logic FAN_EN,
  input wire logic THERM_MEM_CLR,
  input wire logic STOP_CMD,
  input wire logic REF_INC,
  input wire logic NAV_NEXT,
  input wire logic REMOTE_CFG,
  input wire logic PROG_MODE,
  input wire logic LED_REF,
  input wire logic LED_MON
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);

  a_relay_drop: assert property (FAULT_DET |-> ##[1:2] !FAULT_STATUS_RELAY)
    else $error("relay still energized after fault");
  a_relay_cause: assert property ($fell(FAULT_STATUS_RELAY) |-> $past(FAULT_DET) || $past(FAULT_DET, 2))
    else $error("relay dropped without fault");
  a_fan_on: assert property (THERM_VENT_REQ |=> FAN_EN)
    else $error("fan not enabled on request");
  a_fan_off: assert property (!THERM_VENT_REQ |=> !FAN_EN)
    else $error("fan on without request");
  a_stop_pulse: assert property (STOP_CMD |=> !STOP_CMD)
    else $error("stop command longer than one cycle");
  a_dial_ref: assert property ($rose(DIAL_A) && !DIAL_B && !PROG_MODE && !REMOTE_CFG
                               |-> ##[1:3] REF_INC)
    else $error("dial step gave no reference increment");
  a_dial_nav: assert property ($rose(DIAL_A) && !DIAL_B && PROG_MODE |-> ##[1:3] NAV_NEXT)
    else $error("dial step gave no navigation");
  a_blink_pair: assert property ((!REMOTE_CFG && PROG_MODE) [*3] |-> LED_REF == LED_MON)
    else $error("mode leds not blinking together");
  a_remote_dark: assert property (REMOTE_CFG [*3] |-> !LED_REF && !LED_MON)
    else $error("mode leds lit in remote");
  a_clr_pulse: assert property (THERM_MEM_CLR |-> !THERM_RETAIN ##1 !THERM_MEM_CLR)
    else $error("thermal clear pulse wrong");

  c_fault: cover property ($fell(FAULT_STATUS_RELAY));
  c_prog: cover property ($rose(PROG_MODE));
  c_remote: cover property ($rose(REMOTE_CFG));
endmodule : fpc_top_checker

bind fpc_top fpc_top_checker chk (.*);

// ===== dv/fpc_operator.sv
// operator model: keypad keys and quadrature jog dial
`timescale 1ns/100ps
module fpc_operator (
  input  wire logic       clk,
  output logic      [5:0] keys,
  output logic            dial_a,
  output logic            dial_b
);
  initial
  begin
    keys   = 6'h00;
    dial_a = 1'b0;
    dial_b = 1'b0;
  end

  // holds under the debounce span vanish, so callers hold longer; release settles too
  task press(input int k, input int n);
    @(posedge clk);
    keys[k] <= 1'b1;
    repeat (n) @(posedge clk);
    keys[k] <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : press

  // phase b leads the rising edge of a; afterwards b flips so no stale level lingers
  task turn(input logic ccw);
    @(posedge clk);
    dial_b <= ccw;
    @(posedge clk);
    dial_a <= 1'b1;
    repeat (2) @(posedge clk);
    dial_a <= 1'b0;
    dial_b <= !ccw;
    repeat (4) @(posedge clk);
  endtask : turn
endmodule : fpc_operator

// ===== dv/tb_fpc_top.sv
// self-checking bench for the front-panel controller
`timescale 1ns/100ps
module tb_fpc_top;
  typedef struct {int k; int h; logic [9:0] e;} fpc_row_t;
  logic        SYS_CLK = 1'b0;
  logic        SRST, WR, RD, FAULT_DET, FAULT_RESET_IN, THERM_VENT_REQ;
  logic        THERM_RETAIN, STD_FREQ_SET, DIAL_A, DIAL_B, IRQ;
  logic [7:0]  ADDR;
  logic [31:0] WDATA, RDATA;
  logic        FAULT_STATUS_RELAY, FAN_EN, THERM_MEM_CLR, READY_IND, STOP_CMD, RUN_CMD;
  logic        REF_INC, REF_DEC, NAV_NEXT, NAV_PREV, SELECT, EXIT_EVT, DISCARD_EVT;
  logic        REMOTE_CFG, PROG_MODE, LED_REF, LED_MON, LED_CFG, LED_VALUE, LED_UNIT;
  logic [9:0]  DCI_CURRENT, DCI_TIME;
  logic [5:0]  keys;
  logic [9:0]  seen = 10'h000;
  logic [2:0]  lit = 3'h0;
  logic        clr = 1'b0;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  wire         EXIT_KEY = keys[fpc_pkg::K_EXIT];
  wire         MODE_KEY = keys[fpc_pkg::K_MODE];
  wire         STOP_KEY = keys[fpc_pkg::K_STOP];
  wire         RUN_KEY = keys[fpc_pkg::K_RUN];
  wire         CONFIRM_KEY = keys[fpc_pkg::K_CONF];
  wire         DIAL_PUSH = keys[fpc_pkg::K_PUSH];
  wire  [9:0]  pulses = {THERM_MEM_CLR, STOP_CMD, RUN_CMD, REF_INC, REF_DEC, NAV_NEXT,
                         NAV_PREV, SELECT, EXIT_EVT, DISCARD_EVT};
  fpc_row_t    rows [6] = '{'{2, 8, 10'h100}, '{3, 8, 10'h080}, '{4, 8, 10'h004},
                            '{5, 8, 10'h004}, '{0, 8, 10'h002}, '{0, 50, 10'h000}};

  // short counts keep long holds inside a brief run
  fpc_top #(.EXIT_HOLD_CYC(40), .MODE_HOLD_CYC(60), .DEBOUNCE_CYC(4), .BLINK_CYC(8)) dut (.*);
  fpc_operator op (.clk(SYS_CLK), .keys(keys), .dial_a(DIAL_A), .dial_b(DIAL_B));

  always #4 SYS_CLK = ~SYS_CLK;
  // pulses are one cycle wide, so collect them rather than poll
  always @(posedge SYS_CLK) seen <= (clr || SRST) ? 10'h000 : (seen | pulses);

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task give_verdict;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      n_mismatch++;
    end
  endtask : chk

  task settle;
    @(posedge SYS_CLK);
    #1;
  endtask : settle

  task clear;
    @(posedge SYS_CLK);
    clr <= 1'b1;
    @(posedge SYS_CLK);
    clr <= 1'b0;
  endtask : clear

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, e);
  endtask : rchk

  task dial_pair(input logic [9:0] e);
    clear();
    op.turn(1'b0);
    op.turn(1'b1);
    settle();
    chk(seen, e);
  endtask : dial_pair

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (5000) @(posedge SYS_CLK);
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    {SRST, WR, RD, FAULT_DET, FAULT_RESET_IN, THERM_VENT_REQ} = 6'h20;
    {THERM_RETAIN, STD_FREQ_SET} = 2'b01;
    ADDR  = 8'h00;
    WDATA = 32'h0;
    repeat (4) @(posedge SYS_CLK);
    SRST <= 1'b0;
    repeat (4) settle();
    chk({seen, READY_IND, FAULT_STATUS_RELAY, REMOTE_CFG, PROG_MODE}, 14'h200C);
    chk({DCI_TIME, DCI_CURRENT}, 20'h7D2BC);
    rchk(fpc_pkg::ADDR_DCI, 32'h01F402BC);
    rchk(8'h14, 32'h0);
    foreach (rows[i])
    begin
      clear();
      op.press(rows[i].k, rows[i].h);
      settle();
      chk(seen, rows[i].e);
    end
    chk(PROG_MODE, 1'b1);
    dial_pair(10'h018);
    op.press(fpc_pkg::K_MODE, 8);
    settle();
    chk(PROG_MODE, 1'b0);
    dial_pair(10'h060);
    for (int i = 0; i < 24; i++)
    begin
      settle();
      chk($countones({LED_REF, LED_MON, LED_CFG}), 1);
      lit = lit | {LED_REF, LED_MON, LED_CFG};
    end
    chk(lit, 3'h7);
    wr(fpc_pkg::ADDR_IMASK, 32'h3);
    @(posedge SYS_CLK) FAULT_DET <= 1'b1;
    @(posedge SYS_CLK) FAULT_DET <= 1'b0;
    repeat (3) settle();
    chk({FAULT_STATUS_RELAY, IRQ}, 2'b01);
    rchk(fpc_pkg::ADDR_ISTAT, 32'h5);
    @(posedge SYS_CLK) FAULT_RESET_IN <= 1'b1;
    wr(fpc_pkg::ADDR_CTRL, 32'h3);
    repeat (3) settle();
    chk(FAULT_STATUS_RELAY, 1'b1);
    rchk(fpc_pkg::ADDR_ISTAT, 32'h7);
    wr(fpc_pkg::ADDR_ISTAT, 32'h3);
    settle();
    chk(IRQ, 1'b0);
    @(posedge SYS_CLK) THERM_VENT_REQ <= 1'b1;
    repeat (2) settle();
    chk(FAN_EN, 1'b1);
    @(posedge SYS_CLK) THERM_VENT_REQ <= 1'b0;
    repeat (2) settle();
    chk(FAN_EN, 1'b0);
    wr(fpc_pkg::ADDR_CTRL, 32'h10);
    clear();
    op.press(fpc_pkg::K_EXIT, 8);
    settle();
    chk(seen, 10'h001);
    for (int i = 0; i < 16; i++)
    begin
      settle();
      chk({LED_CFG, LED_VALUE}, 2'b11);
    end
    wr(fpc_pkg::ADDR_CTRL, 32'h40);
    settle();
    chk({LED_VALUE, LED_UNIT}, 2'b01);
    wr(fpc_pkg::ADDR_CTRL, 32'h20);
    settle();
    chk({LED_VALUE, LED_UNIT}, 2'b10);
    op.press(fpc_pkg::K_MODE, 70);
    settle();
    chk({REMOTE_CFG, PROG_MODE}, 2'b10);
    op.press(fpc_pkg::K_EXIT, 50);
    settle();
    chk(PROG_MODE, 1'b0);
    clear();
    op.press(fpc_pkg::K_RUN, 8);
    settle();
    chk(seen, 10'h000);
    wr(fpc_pkg::ADDR_CTRL, 32'h4);
    clear();
    op.press(fpc_pkg::K_RUN, 8);
    settle();
    chk(seen, 10'h080);
    @(posedge SYS_CLK);
    SRST         <= 1'b1;
    THERM_RETAIN <= 1'b1;
    STD_FREQ_SET <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    SRST <= 1'b0;
    repeat (4) settle();
    chk({seen, READY_IND, FAULT_STATUS_RELAY, REMOTE_CFG, PROG_MODE}, 14'h0004);
    give_verdict();
  end
endmodule : tb_fpc_top
